/* rtl/fcpdg_defs.vh */
// constants of the cyclic process-data gate
// Contract
// R1: a command field written with the value it already holds causes no action.
// R2: the master retriggers totalizer reset or fault clear by writing nonzero, then zero.
// R3: the master sets mask weight 2 before writing a flow target.
// R4: the master sets mask weight 1024 before writing a pressure target.
// R5: the master sets mask weights 4 and 8 (value 12) for valve drive and mode.
// R6: mode code 10 selects manual valve control, the valve drive percent driving the valve.
// R7: mode code 5 selects pressure control and code 1 selects flow control.
// R8: the master writes mode code 1 again to regain flow target control.
// R9: held targets take effect at once on a mode switch while their mask bits stay set.
// R10: the master enables mask weight 128 and echoes the fault flags into fault clear.
// R11: an acknowledged alarm is not reported again until reset or soft restart.
// R12: slew time 0 disables ramping; 200 to 10000 gives the ramp time in ms.
// R13: the flow target is applied only in mode 0 (automatic) or 1 (digital).
// R14: the mask is cleared at power-up and writes to fields with clear bits are dropped.
// R15: mask bits 0..12 enable the output fields in their fixed order.
// R16: the mask is evaluated in the same cycle as the field updates it gates.
`ifndef FCPDG_DEFS_VH
`define FCPDG_DEFS_VH

// write-enable mask bit positions
`define FCPDG_EN_TOTAL 0
`define FCPDG_EN_FLOW 1
`define FCPDG_EN_VALVE 2
`define FCPDG_EN_MODE 3
`define FCPDG_EN_SLEW 4
`define FCPDG_EN_FPID 5
`define FCPDG_EN_FACT 6
`define FCPDG_EN_FCLR 7
`define FCPDG_EN_STORE 8
`define FCPDG_EN_TABLE 9
`define FCPDG_EN_PRESS 10
`define FCPDG_EN_PPID 11
`define FCPDG_EN_RESTART 12
`define FCPDG_MASK_W 13

// control mode codes
`define FCPDG_MODE_AUTO 16'h0000
`define FCPDG_MODE_DIGITAL 16'h0001
`define FCPDG_MODE_PRESS 16'h0005
`define FCPDG_MODE_VALVE 16'h000A

// slew time limits in ms
`define FCPDG_SLEW_OFF 16'h0000
`define FCPDG_SLEW_MIN 16'h00C8
`define FCPDG_SLEW_MAX 16'h2710

// reset values
`define FCPDG_RST16 16'h0000
`define FCPDG_RST32 32'h0000_0000

`endif

/* rtl/fcpdg_gate.v */
// cyclic process-data register gate of a flow/pressure controller
`timescale 1ns/10ps
`include "fcpdg_defs.vh"

module fcpdg_gate (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_B,
  // output image from the fieldbus master, taken on PDO_WR_STB
  input wire PDO_WR_STB,
  input wire [15:0] WR_MASK,
  input wire [31:0] WR_TOTAL,
  input wire [31:0] WR_FLOW_TGT,
  input wire [31:0] WR_VALVE,
  input wire [15:0] WR_MODE,
  input wire [15:0] WR_SLEW,
  input wire [15:0] WR_FPID,
  input wire [15:0] WR_FACT,
  input wire [15:0] WR_FCLR,
  input wire [15:0] WR_STORE,
  input wire [15:0] WR_TABLE,
  input wire [31:0] WR_PRESS_TGT,
  input wire [15:0] WR_PPID,
  input wire [15:0] WR_RESTART,
  // measured values and fault sources from device logic
  input wire [31:0] GAS_FLOW_IN,
  input wire [31:0] TOTAL_IN,
  input wire [15:0] FAULT_RAW,
  // input image to the master
  output reg [31:0] RD_GAS_FLOW,
  output reg [31:0] RD_TOTAL,
  output reg [15:0] RD_SLEW,
  output reg [31:0] RD_FLOW_TGT,
  output reg [15:0] RD_FAULT_FLAGS,
  output reg [15:0] RD_MODE,
  // applied control values
  output reg [31:0] FLOW_SP_OUT,
  output reg [31:0] PRESS_SP_OUT,
  output reg [31:0] VALVE_OUT,
  output reg FLOW_CTRL_ON,
  output reg PRESS_CTRL_ON,
  output reg VALVE_MANUAL_ON,
  output reg SLEW_ON,
  output reg [15:0] SLEW_MS,
  // held setting fields
  output reg [15:0] FPID_SEL,
  output reg [15:0] PPID_SEL,
  output reg [15:0] STORE_SEL,
  output reg [15:0] TABLE_SEL,
  // one-cycle action pulses
  output reg TOTAL_RESET_PLS,
  output reg FACTORY_RESTORE_PLS,
  output reg SOFT_RESTART_PLS
);

  ////////////////////////////////////////////////////////////////////////////
  // accept test, shared by every gated field

  function accept;
    input en;
    input [31:0] new_v;
    input [31:0] old_v;
    begin
      accept = en & (new_v != old_v); // [R1] [R14]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // held fields

  reg [`FCPDG_MASK_W-1:0] mask_q;
  reg [31:0] total_q, flow_q, valve_q, press_q;
  reg [15:0] mode_q, slew_q, fact_q, fclr_q, restart_q;
  reg [15:0] flags_q, acked_q;

  // the fresh mask gates this very exchange
  wire [`FCPDG_MASK_W-1:0] en_w = PDO_WR_STB ?
    WR_MASK[`FCPDG_MASK_W-1:0] : {`FCPDG_MASK_W{1'b0}}; // [R16] [R15]

  wire tot_w = accept(en_w[`FCPDG_EN_TOTAL], WR_TOTAL, total_q);
  wire flow_w = accept(en_w[`FCPDG_EN_FLOW], WR_FLOW_TGT, flow_q);
  wire valve_w = accept(en_w[`FCPDG_EN_VALVE], WR_VALVE, valve_q);
  wire mode_w = accept(en_w[`FCPDG_EN_MODE], {16'h0000, WR_MODE},
    {16'h0000, mode_q});
  // out-of-range slew times are refused and the old value kept
  wire slew_ok = (WR_SLEW == `FCPDG_SLEW_OFF) ||
    ((WR_SLEW >= `FCPDG_SLEW_MIN) && (WR_SLEW <= `FCPDG_SLEW_MAX)); // [R12]
  wire slew_w = slew_ok & accept(en_w[`FCPDG_EN_SLEW], {16'h0000, WR_SLEW},
    {16'h0000, slew_q});
  wire fpid_w = accept(en_w[`FCPDG_EN_FPID], {16'h0000, WR_FPID},
    {16'h0000, FPID_SEL});
  wire fact_w = accept(en_w[`FCPDG_EN_FACT], {16'h0000, WR_FACT},
    {16'h0000, fact_q});
  wire fclr_w = accept(en_w[`FCPDG_EN_FCLR], {16'h0000, WR_FCLR},
    {16'h0000, fclr_q}); // [R1]
  wire store_w = accept(en_w[`FCPDG_EN_STORE], {16'h0000, WR_STORE},
    {16'h0000, STORE_SEL});
  wire table_w = accept(en_w[`FCPDG_EN_TABLE], {16'h0000, WR_TABLE},
    {16'h0000, TABLE_SEL});
  wire press_w = accept(en_w[`FCPDG_EN_PRESS], WR_PRESS_TGT, press_q);
  wire ppid_w = accept(en_w[`FCPDG_EN_PPID], {16'h0000, WR_PPID},
    {16'h0000, PPID_SEL});
  wire rst_w = accept(en_w[`FCPDG_EN_RESTART], {16'h0000, WR_RESTART},
    {16'h0000, restart_q});

  // mode in force from the next edge
  wire [15:0] mode_d = mode_w ? WR_MODE : mode_q;
  wire [31:0] flow_d = flow_w ? WR_FLOW_TGT : flow_q;
  wire [31:0] valve_d = valve_w ? WR_VALVE : valve_q;
  wire [31:0] press_d = press_w ? WR_PRESS_TGT : press_q;

  wire is_flow = (mode_d == `FCPDG_MODE_AUTO) ||
    (mode_d == `FCPDG_MODE_DIGITAL); // [R13] [R7]
  wire is_press = (mode_d == `FCPDG_MODE_PRESS); // [R7]
  wire is_valve = (mode_d == `FCPDG_MODE_VALVE); // [R6]

  // a cleared bit only hides the flag if the echo is a real change
  wire [15:0] clr_bits = fclr_w ? WR_FCLR : `FCPDG_RST16; // [R10]
  wire [15:0] acked_d = rst_w ? `FCPDG_RST16 : (acked_q | clr_bits); // [R11]
  wire [15:0] set_bits = FAULT_RAW & ~acked_d; // [R11]

  ////////////////////////////////////////////////////////////////////////////
  // state update

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_q <= {`FCPDG_MASK_W{1'b0}}; // [R14]
      total_q <= `FCPDG_RST32;
      flow_q <= `FCPDG_RST32;
      valve_q <= `FCPDG_RST32;
      press_q <= `FCPDG_RST32;
      mode_q <= `FCPDG_MODE_AUTO;
      slew_q <= `FCPDG_SLEW_OFF;
      fact_q <= `FCPDG_RST16;
      fclr_q <= `FCPDG_RST16;
      restart_q <= `FCPDG_RST16;
      flags_q <= `FCPDG_RST16;
      acked_q <= `FCPDG_RST16;
      FPID_SEL <= `FCPDG_RST16;
      PPID_SEL <= `FCPDG_RST16;
      STORE_SEL <= `FCPDG_RST16;
      TABLE_SEL <= `FCPDG_RST16;
      FLOW_SP_OUT <= `FCPDG_RST32;
      PRESS_SP_OUT <= `FCPDG_RST32;
      VALVE_OUT <= `FCPDG_RST32;
      FLOW_CTRL_ON <= 1'b1;
      PRESS_CTRL_ON <= 1'b0;
      VALVE_MANUAL_ON <= 1'b0;
      SLEW_ON <= 1'b0;
      SLEW_MS <= `FCPDG_SLEW_OFF;
      TOTAL_RESET_PLS <= 1'b0;
      FACTORY_RESTORE_PLS <= 1'b0;
      SOFT_RESTART_PLS <= 1'b0;
      RD_GAS_FLOW <= `FCPDG_RST32;
      RD_TOTAL <= `FCPDG_RST32;
      RD_SLEW <= `FCPDG_RST16;
      RD_FLOW_TGT <= `FCPDG_RST32;
      RD_FAULT_FLAGS <= `FCPDG_RST16;
      RD_MODE <= `FCPDG_RST16;
    end else begin
      if (PDO_WR_STB) begin
        mask_q <= WR_MASK[`FCPDG_MASK_W-1:0]; // [R16]
      end
      if (tot_w) begin
        total_q <= WR_TOTAL;
      end
      flow_q <= flow_d; // [R14]
      valve_q <= valve_d;
      press_q <= press_d;
      mode_q <= mode_d; // [R8]
      if (slew_w) begin
        slew_q <= WR_SLEW;
      end
      if (fact_w) begin
        fact_q <= WR_FACT;
      end
      if (fclr_w) begin
        fclr_q <= WR_FCLR;
      end
      if (rst_w) begin
        restart_q <= WR_RESTART;
      end
      if (fpid_w) begin
        FPID_SEL <= WR_FPID;
      end
      if (ppid_w) begin
        PPID_SEL <= WR_PPID;
      end
      if (store_w) begin
        STORE_SEL <= WR_STORE;
      end
      if (table_w) begin
        TABLE_SEL <= WR_TABLE;
      end
      // a new fault outside the echoed bits survives the clearing cycle
      flags_q <= (flags_q & ~clr_bits & ~acked_d) | set_bits; // [R10] [R11]
      acked_q <= acked_d;
      // targets written earlier apply at once on a mode switch,
      // but only while their enable bit is still set
      if (is_flow && (en_w[`FCPDG_EN_FLOW] ||
          (!PDO_WR_STB && mask_q[`FCPDG_EN_FLOW]))) begin
        FLOW_SP_OUT <= flow_d; // [R9] [R13]
      end
      if (is_press && (en_w[`FCPDG_EN_PRESS] ||
          (!PDO_WR_STB && mask_q[`FCPDG_EN_PRESS]))) begin
        PRESS_SP_OUT <= press_d; // [R9] [R7]
      end
      if (is_valve && (en_w[`FCPDG_EN_VALVE] ||
          (!PDO_WR_STB && mask_q[`FCPDG_EN_VALVE]))) begin
        VALVE_OUT <= valve_d; // [R9] [R6]
      end
      FLOW_CTRL_ON <= is_flow;
      PRESS_CTRL_ON <= is_press;
      VALVE_MANUAL_ON <= is_valve;
      SLEW_ON <= (slew_w ? WR_SLEW : slew_q) != `FCPDG_SLEW_OFF; // [R12]
      SLEW_MS <= slew_w ? WR_SLEW : slew_q;
      // commands act on change only, so zero-after-nonzero fires them too
      TOTAL_RESET_PLS <= tot_w; // [R1]
      FACTORY_RESTORE_PLS <= fact_w; // [R1]
      SOFT_RESTART_PLS <= rst_w; // [R1]
      RD_GAS_FLOW <= GAS_FLOW_IN;
      RD_TOTAL <= TOTAL_IN;
      RD_SLEW <= slew_w ? WR_SLEW : slew_q;
      RD_FLOW_TGT <= flow_d;
      RD_FAULT_FLAGS <= (flags_q & ~clr_bits & ~acked_d) | set_bits;
      RD_MODE <= mode_d;
    end
  end

endmodule

/* dv/fcpdg_checker.sv */
// port assertions for the process-data gate
`timescale 1ns/10ps
module fcpdg_checker (
  // clock and reset
  input wire CORE_CLK,
  input wire RST_B,
  // output image
  input wire PDO_WR_STB,
  input wire [15:0] WR_MASK,
  input wire [15:0] WR_MODE,
  // held and applied values
  input wire [15:0] RD_MODE,
  input wire [15:0] RD_SLEW,
  input wire FLOW_CTRL_ON,
  input wire PRESS_CTRL_ON,
  input wire VALVE_MANUAL_ON,
  input wire SLEW_ON,
  input wire [15:0] SLEW_MS,
  input wire TOTAL_RESET_PLS,
  input wire SOFT_RESTART_PLS
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////
  mode_write_gated_a: assert property (
    $changed(RD_MODE) |-> $past(PDO_WR_STB && WR_MASK[3])
    && RD_MODE == $past(WR_MODE)) else $error("mode changed ungated");
  total_pulse_gated_a: assert property (
    TOTAL_RESET_PLS |-> $past(PDO_WR_STB && WR_MASK[0]))
    else $error("totalizer pulse without enabled write");
  restart_pulse_gated_a: assert property (
    SOFT_RESTART_PLS |-> $past(PDO_WR_STB && WR_MASK[12]))
    else $error("restart pulse without enabled write");
  manual_decode_a: assert property (
    VALVE_MANUAL_ON == (RD_MODE == 16'h000A)) else $error("manual decode");
  press_decode_a: assert property (
    PRESS_CTRL_ON == (RD_MODE == 16'h0005)) else $error("pressure decode");
  flow_decode_a: assert property (
    FLOW_CTRL_ON == (RD_MODE <= 16'h0001)) else $error("flow decode");
  slew_range_a: assert property (
    RD_SLEW == 16'h0000 || (RD_SLEW >= 16'h00C8 && RD_SLEW <= 16'h2710))
    else $error("slew time out of range");
  slew_enable_a: assert property (
    SLEW_ON == (SLEW_MS != 16'h0000)) else $error("slew enable wrong");
  cover property (VALVE_MANUAL_ON);
  cover property (PRESS_CTRL_ON);
  cover property (SOFT_RESTART_PLS);
endmodule
bind fcpdg_gate fcpdg_checker i_fcpdg_checker (.CORE_CLK(CORE_CLK),
  .RST_B(RST_B), .PDO_WR_STB(PDO_WR_STB), .WR_MASK(WR_MASK),
  .WR_MODE(WR_MODE), .RD_MODE(RD_MODE), .RD_SLEW(RD_SLEW),
  .FLOW_CTRL_ON(FLOW_CTRL_ON), .PRESS_CTRL_ON(PRESS_CTRL_ON),
  .VALVE_MANUAL_ON(VALVE_MANUAL_ON), .SLEW_ON(SLEW_ON), .SLEW_MS(SLEW_MS),
  .TOTAL_RESET_PLS(TOTAL_RESET_PLS), .SOFT_RESTART_PLS(SOFT_RESTART_PLS));

/* dv/fcpdg_master.sv */
// fieldbus master model sending the cyclic output image
`timescale 1ns/10ps
module fcpdg_master (
  // clock
  input wire clk,
  // output image
  output logic stb = 1'b0,
  output logic [15:0] mask = 16'h0000,
  output logic [15:0] mode = 16'h0000,
  output logic [15:0] slew = 16'h0000,
  output logic [15:0] fclr = 16'h0000,
  output logic [15:0] rs = 16'h0000,
  output logic [15:0] aux = 16'h0000,
  output logic [31:0] tot = 32'h0000_0000,
  output logic [31:0] flow = 32'h0000_0000,
  output logic [31:0] valve = 32'h0000_0000,
  output logic [31:0] press = 32'h0000_0000
);
  // the image persists between strobes, so resending a field is a no-op
  task automatic wr(input logic [15:0] m, input int f,
                    input logic [31:0] v);
    @(negedge clk);
    mask = m;
    case (f)
      0: tot = v;
      1: flow = v;
      2: valve = v;
      3: mode = v[15:0];
      4: slew = v[15:0];
      5, 6, 8, 9, 11: aux = v[15:0];
      7: fclr = v[15:0];
      10: press = v;
      default: rs = v[15:0];
    endcase
    stb = 1'b1;
    @(negedge clk);
    stb = 1'b0;
  endtask
endmodule

/* dv/fcpdg_gate_bench.sv */
// self-checking bench for the process-data gate
`timescale 1ns/10ps
module fcpdg_gate_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] fault = 16'h0000;
  logic [31:0] gas = 32'h0000_1234;
  logic [31:0] tot_in = 32'h0000_5678;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  wire stb, f_on, p_on, v_on, s_on, t_pls, r_pls, x_pls;
  wire [15:0] mask, mode, slew, fclr, rs, rd_mode, rd_flt, slew_ms, aux;
  wire [15:0] rd_slew, fpid, ppid, store, tbl;
  wire [31:0] tot, flow, valve, press, rd_flow, rd_gas, f_sp, p_sp, v_out;
  wire [31:0] rd_tot;
  fcpdg_master i_fcpdg_master (.clk(clk), .stb(stb), .mask(mask),
    .mode(mode), .slew(slew), .fclr(fclr), .rs(rs), .aux(aux), .tot(tot),
    .flow(flow), .valve(valve), .press(press));
  // one shared field word feeds the setting fields, so only the mask
  // decides which of them takes it
  fcpdg_gate i_fcpdg_gate (
    .CORE_CLK(clk), .RST_B(rst_b), .PDO_WR_STB(stb), .WR_MASK(mask),
    .WR_TOTAL(tot), .WR_FLOW_TGT(flow), .WR_VALVE(valve), .WR_MODE(mode),
    .WR_SLEW(slew), .WR_FPID(aux), .WR_FACT(aux),
    .WR_FCLR(fclr), .WR_STORE(aux), .WR_TABLE(aux),
    .WR_PRESS_TGT(press), .WR_PPID(aux), .WR_RESTART(rs),
    .GAS_FLOW_IN(gas), .TOTAL_IN(tot_in), .FAULT_RAW(fault),
    .RD_GAS_FLOW(rd_gas), .RD_TOTAL(rd_tot), .RD_SLEW(rd_slew),
    .RD_FLOW_TGT(rd_flow),
    .RD_FAULT_FLAGS(rd_flt), .RD_MODE(rd_mode), .FLOW_SP_OUT(f_sp),
    .PRESS_SP_OUT(p_sp), .VALVE_OUT(v_out), .FLOW_CTRL_ON(f_on),
    .PRESS_CTRL_ON(p_on), .VALVE_MANUAL_ON(v_on), .SLEW_ON(s_on),
    .SLEW_MS(slew_ms), .FPID_SEL(fpid), .PPID_SEL(ppid), .STORE_SEL(store),
    .TABLE_SEL(tbl), .TOTAL_RESET_PLS(t_pls), .FACTORY_RESTORE_PLS(x_pls),
    .SOFT_RESTART_PLS(r_pls));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] m, input int f,
                    input logic [31:0] v);
    i_fcpdg_master.wr(m, f, v);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  // a hang ends the run as a failure instead of stalling forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    tick(4);
    rst_b = 1'b1;
    tick(1);
    chk(f_on, 1);
    chk(rd_gas, gas);
    chk(rd_tot, tot_in);
    wr(16'h0000, 1, 32'h0000_0007);
    chk(rd_flow, 0);
    wr(16'h0002, 1, 32'h0000_0007);
    chk(rd_flow, 32'h0000_0007);
    tick(1);
    chk(f_sp, 32'h0000_0007);
    wr(16'h000C, 3, 32'h0000_000A);
    chk(v_on, 1);
    chk(f_on, 0);
    wr(16'h000C, 2, 32'h0000_0019);
    tick(1);
    chk(v_out, 32'h0000_0019);
    wr(16'h040C, 10, 32'h0000_0003);
    tick(1);
    chk(p_sp, 0);
    wr(16'h040C, 3, 32'h0000_0005);
    tick(1);
    chk(p_on, 1);
    chk(p_sp, 32'h0000_0003);
    wr(16'h040E, 1, 32'h0000_0009);
    chk(f_sp, 32'h0000_0007);
    wr(16'h040E, 3, 32'h0000_0001);
    tick(1);
    chk(f_on, 1);
    chk(f_sp, 32'h0000_0009);
    wr(16'h0001, 0, 32'h0000_0001);
    chk(t_pls, 1);
    tick(1);
    chk(t_pls, 0);
    wr(16'h0001, 0, 32'h0000_0001);
    chk(t_pls, 0);
    wr(16'h0001, 0, 32'h0000_0000);
    chk(t_pls, 1);
    wr(16'h0010, 4, 32'h0000_0096);
    chk(s_on, 0);
    wr(16'h0010, 4, 32'h0000_2711);
    chk(slew_ms, 0);
    wr(16'h0010, 4, 32'h0000_2710);
    chk(slew_ms, 32'h0000_2710);
    wr(16'h0010, 4, 32'h0000_00C8);
    chk(rd_slew, 32'h0000_00C8);
    chk(s_on, 1);
    wr(16'h0010, 4, 32'h0000_0000);
    chk(s_on, 0);
    fault = 16'h0004;
    tick(2);
    chk(rd_flt, 32'h0000_0004);
    wr(16'h0080, 7, 32'h0000_0004);
    chk(rd_flt, 0);
    tick(3);
    chk(rd_flt, 0);
    wr(16'h1000, 12, 32'h0000_0001);
    chk(r_pls, 1);
    tick(2);
    chk(rd_flt, 32'h0000_0004);
    wr(16'h0020, 5, 32'h0000_0003);
    chk(fpid, 16'h0003);
    chk(x_pls, 0);
    chk(ppid, 0);
    wr(16'h0040, 6, 32'h0000_0003);
    chk(x_pls, 1);
    wr(16'h0A00, 9, 32'h0000_0003);
    chk(tbl, 16'h0003);
    chk(ppid, 16'h0003);
    chk(store, 0);
    wr(16'h0100, 8, 32'h0000_0005);
    chk(store, 16'h0005);
    chk(tbl, 16'h0003);
    stop_test();
  end
endmodule
